// ### tsc_regs.vh
`ifndef TSC_REGS_VH
`define TSC_REGS_VH
// ==========================================
// Register offsets (byte addresses in hub MMIO space)
`define TSC_ADDR_W            16
`define TSC_OFF_CONTROL       16'h1041
`define TSC_OFF_STATUS        16'h1044
`define TSC_OFF_READING       16'h1046
// ==========================================
// Control register fields
`define TSC_CTL_ENABLE_BIT    15
`define TSC_CTL_HYST_HI       13
`define TSC_CTL_HYST_LO       10
`define TSC_CTL_SEM_BIT       8
`define TSC_CTL_RESET         16'h0000
// ==========================================
// Status register fields
`define TSC_STS_VALID_BIT     10
`define TSC_STS_CAT_BIT       5
`define TSC_STS_HOT_BIT       4
`define TSC_STS_AUX_HI        3
`define TSC_STS_AUX_LO        0
`define TSC_STS_RESET         16'h0000
// ==========================================
// Lock register field
`define TSC_LOCK_BIT          7
// ==========================================
// Sizes
`define TSC_TEMP_W            8
`define TSC_HYST_W            4
`define TSC_NUM_TRIPS         6
`define TSC_READING_RESET     8'hFF
`endif

// ### tsc_trip_cmp.v
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// One trip comparator with hysteresis
module tsc_trip_cmp #(
  parameter TEMP_W = 8,
  parameter HYST_W = 4
) (
  input  wire              clk_in,
  input  wire              sys_rst_in,
  input  wire              enable_in,
  input  wire [TEMP_W-1:0] temp_in,
  input  wire [TEMP_W-1:0] thresh_in,
  input  wire [HYST_W-1:0] hyst_in,
  output wire              trip_out
);
  reg              trip_q;
  reg              trip_d;
  reg [TEMP_W:0]   limit;

  // Widened by one bit so threshold plus offset cannot wrap
  always @* begin
    limit = {1'b0, thresh_in};
    if (trip_q && (hyst_in != {HYST_W{1'b0}})) begin
      limit = {1'b0, thresh_in} + {{(TEMP_W+1-HYST_W){1'b0}}, hyst_in};
    end
    trip_d = enable_in && ({1'b0, temp_in} > limit);
  end

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      trip_q <= 1'b0;
    end else begin
      trip_q <= trip_d;
    end
  end

  assign trip_out = trip_q;
endmodule // tsc_trip_cmp
`default_nettype wire

// ### tsc_sync2.v
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Two-flop level synchroniser
module tsc_sync2 #(
  parameter W = 1
) (
  input  wire         clk_in,
  input  wire         sys_rst_in,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule // tsc_sync2
`default_nettype wire

// ### tsc_thermal_ctrl.v
// Function
// - Control bit 15 powers the sensor when 1 and disables it when 0.
// - Once lock bit 7 is set, writes to the power enable bit are ignored.
// - A hysteresis field of zero adds no offset to any trip threshold.
// - A nonzero hysteresis N adds N steps to each threshold whose trip is asserted.
// - After reset the first semaphore read returns 0 and later reads return 1.
// - Writing 1 to the semaphore makes the next read 0; writing 0 does nothing.
// - Status bit 10 reads 1 only when the thermometer has converged on a reading.
// - The valid bit reads 0 when thermometer mode is off, out of range, or converting.
// - Status bit 5 reads 1 while temperature is above the catastrophic threshold.
// - The status register is read-only and shows live trip and valid conditions.
// - Status bit 4 reads 1 while temperature is above the hot threshold.
// - Status bits 3 to 0 read 1 while temperature is above aux thresholds 3 to 0.
// - The 8-bit reading is straight binary and tracks temperature only while valid.
`timescale 1ns/1ps
`default_nettype none
`include "tsc_regs.vh"
module tsc_thermal_ctrl #(
  parameter TEMP_W = `TSC_TEMP_W,
  parameter HYST_W = `TSC_HYST_W
) (
  input  wire                       clk_in,
  input  wire                       sys_rst_in,
  // Register port
  input  wire [`TSC_ADDR_W-1:0]     reg_addr_in,
  input  wire                       reg_wr_in,
  input  wire                       reg_rd_in,
  input  wire [15:0]                reg_wdata_in,
  output reg  [15:0]                reg_rdata_out,
  output wire                       reg_ack_out,
  // Lock register bit 7, from the thermal lock register
  input  wire                       lock_in,
  // Trip thresholds, programmed elsewhere
  input  wire [TEMP_W-1:0]          cat_thresh_in,
  input  wire [TEMP_W-1:0]          hot_thresh_in,
  input  wire [4*TEMP_W-1:0]        aux_thresh_in,
  // Analog sensor front end, asynchronous
  input  wire [TEMP_W-1:0]          sensor_temp_in,
  input  wire                       sensor_conv_done_in,
  input  wire                       sensor_in_range_in,
  output wire                       sensor_power_enable_out,
  output wire [HYST_W-1:0]          hysteresis_amount_out,
  output wire [TEMP_W-1:0]          temperature_reading_out,
  output wire [15:0]                status_out
);
  // ==========================================
  // Control state
  reg              sensor_power_enable_q;
  reg [HYST_W-1:0] hysteresis_amount_q;
  reg              ownership_semaphore_q;
  reg [TEMP_W-1:0] temperature_reading_q;
  reg [TEMP_W-1:0] temp_hold_q;
  reg              valid_q;

  wire wr_ctl = reg_wr_in && (reg_addr_in == `TSC_OFF_CONTROL);
  wire rd_ctl = reg_rd_in && (reg_addr_in == `TSC_OFF_CONTROL);

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      sensor_power_enable_q <= 1'b0;
      hysteresis_amount_q   <= {HYST_W{1'b0}};
      ownership_semaphore_q <= 1'b0;
    end else begin
      if (wr_ctl && !lock_in) begin
        sensor_power_enable_q <= reg_wdata_in[`TSC_CTL_ENABLE_BIT];
      end
      if (wr_ctl) begin
        hysteresis_amount_q <= reg_wdata_in[`TSC_CTL_HYST_HI:`TSC_CTL_HYST_LO];
      end
      // Release on write wins over a read in the same cycle
      if (wr_ctl && reg_wdata_in[`TSC_CTL_SEM_BIT]) begin
        ownership_semaphore_q <= 1'b0;
      end else if (rd_ctl) begin
        ownership_semaphore_q <= 1'b1;
      end
    end
  end

  // ==========================================
  // Sensor input crossing
  wire [TEMP_W-1:0] temp_s;
  wire              done_s;
  wire              range_s;

  tsc_sync2 #(.W(TEMP_W + 2)) u_sync (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   ({sensor_temp_in, sensor_conv_done_in, sensor_in_range_in}),
    .sync_out   ({temp_s, done_s, range_s})
  );

  // Temperature bus must hold still for two samples before it is taken as a reading,
  // since bits of a multi-bit bus may cross on different edges
  wire temp_stable = (temp_s == temp_hold_q);
  wire valid_d     = sensor_power_enable_q && done_s && range_s && temp_stable;

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      temp_hold_q           <= {TEMP_W{1'b0}};
      valid_q               <= 1'b0;
      temperature_reading_q <= `TSC_READING_RESET;
    end else begin
      temp_hold_q <= temp_s;
      valid_q     <= valid_d;
      if (valid_d) begin
        temperature_reading_q <= temp_s;
      end
    end
  end

  // ==========================================
  // Trip comparators: aux0..aux3, hot, catastrophic
  wire [`TSC_NUM_TRIPS-1:0]        trips;
  wire [`TSC_NUM_TRIPS*TEMP_W-1:0] thresholds = {cat_thresh_in, hot_thresh_in, aux_thresh_in};

  genvar gi;
  generate
    for (gi = 0; gi < `TSC_NUM_TRIPS; gi = gi + 1) begin : g_trip
      tsc_trip_cmp #(.TEMP_W(TEMP_W), .HYST_W(HYST_W)) u_cmp (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .enable_in  (sensor_power_enable_q),
        .temp_in    (temp_s),
        .thresh_in  (thresholds[gi*TEMP_W +: TEMP_W]),
        .hyst_in    (hysteresis_amount_q),
        .trip_out   (trips[gi])
      );
    end
  endgenerate

  // ==========================================
  // Register views
  reg [15:0] ctl_view;
  reg [15:0] sts_view;

  always @* begin
    ctl_view = `TSC_CTL_RESET;
    ctl_view[`TSC_CTL_ENABLE_BIT] = sensor_power_enable_q;
    ctl_view[`TSC_CTL_HYST_HI:`TSC_CTL_HYST_LO] = hysteresis_amount_q;
    ctl_view[`TSC_CTL_SEM_BIT] = ownership_semaphore_q;
    sts_view = `TSC_STS_RESET;
    sts_view[`TSC_STS_VALID_BIT] = valid_q;
    sts_view[`TSC_STS_CAT_BIT] = trips[5];
    sts_view[`TSC_STS_HOT_BIT] = trips[4];
    sts_view[`TSC_STS_AUX_HI:`TSC_STS_AUX_LO] = trips[3:0];
  end

  // Status has no write path at all
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `TSC_OFF_CONTROL: reg_rdata_out <= ctl_view;
        `TSC_OFF_STATUS:  reg_rdata_out <= sts_view;
        `TSC_OFF_READING: reg_rdata_out <= {{(16-TEMP_W){1'b0}}, temperature_reading_q};
        default:          reg_rdata_out <= 16'h0000;
      endcase
    end
  end

  reg ack_q;
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= reg_rd_in || reg_wr_in;
    end
  end

  assign reg_ack_out             = ack_q;
  assign sensor_power_enable_out = sensor_power_enable_q;
  assign hysteresis_amount_out   = hysteresis_amount_q;
  assign temperature_reading_out = temperature_reading_q;
  assign status_out              = sts_view;
endmodule // tsc_thermal_ctrl
`default_nettype wire

// ### tsc_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "tsc_regs.vh"
module tsc_checker (
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic        lock_in,
  input wire logic        sensor_power_enable_out,
  input wire logic [3:0]  hysteresis_amount_out,
  input wire logic [7:0]  temperature_reading_out,
  input wire logic [15:0] status_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  wire ctl = reg_addr_in == `TSC_OFF_CONTROL;
  // ==========================================
  // Register side
  property p_en; reg_wr_in && ctl && !lock_in |=> sensor_power_enable_out == $past(reg_wdata_in[15]); endproperty
  a_en: assert property (p_en) else $error("enable not written");
  property p_lock; lock_in |=> sensor_power_enable_out == $past(sensor_power_enable_out); endproperty
  a_lock: assert property (p_lock) else $error("enable moved while locked");
  property p_hyst; reg_wr_in && ctl |=> hysteresis_amount_out == $past(reg_wdata_in[13:10]); endproperty
  a_hyst: assert property (p_hyst) else $error("hysteresis not written");
  property p_ctl_rsvd; reg_rd_in && ctl |=> (reg_rdata_out & 16'h42FF) == 16'h0000; endproperty
  a_ctl_rsvd: assert property (p_ctl_rsvd) else $error("control reserved bits set");
  // Live status mirrors what a read returns
  property p_sts; reg_rd_in && reg_addr_in == `TSC_OFF_STATUS |=> reg_rdata_out == $past(status_out); endproperty
  a_sts: assert property (p_sts) else $error("status read mismatch");
  property p_rdg; reg_rd_in && reg_addr_in == `TSC_OFF_READING |=> reg_rdata_out[7:0] == $past(temperature_reading_out); endproperty
  a_rdg: assert property (p_rdg) else $error("reading read mismatch");
  property p_sts_rsvd; (status_out & 16'hFBC0) == 16'h0000; endproperty
  a_sts_rsvd: assert property (p_sts_rsvd) else $error("status reserved bits set");
  property p_off; !sensor_power_enable_out |=> status_out == 16'h0000; endproperty
  a_off: assert property (p_off) else $error("status set while unpowered");
endmodule // tsc_checker
bind tsc_thermal_ctrl tsc_checker i_tsc_checker (.clk_in, .sys_rst_in, .reg_addr_in, .reg_wr_in, .reg_rd_in,
  .reg_wdata_in, .reg_rdata_out, .lock_in, .sensor_power_enable_out, .hysteresis_amount_out,
  .temperature_reading_out, .status_out);
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tsc_regs.vh"
module tb_top;
  localparam logic [15:0] C = `TSC_OFF_CONTROL;
  localparam logic [15:0] S = `TSC_OFF_STATUS;
  logic        clk_in, sys_rst_in, wr, rd, lock, done, rng, ack, en;
  logic [15:0] addr, wdata, rdata, sts, v;
  logic [7:0]  temp, rdg;
  logic [3:0]  hyst;
  int          num_errors, tests_run;
  // Thresholds tied: cat 80h, hot 60h, aux3..0 40h/30h/20h/10h
  tsc_thermal_ctrl i_tsc_thermal_ctrl (.clk_in, .sys_rst_in, .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_ack_out(ack), .lock_in(lock), .cat_thresh_in(8'h80),
    .hot_thresh_in(8'h60), .aux_thresh_in(32'h40302010), .sensor_temp_in(temp), .sensor_conv_done_in(done),
    .sensor_in_range_in(rng), .sensor_power_enable_out(en), .hysteresis_amount_out(hyst),
    .temperature_reading_out(rdg), .status_out(sts));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // ==========================================
  // Access and compare helpers
  task automatic chk(input string n, input logic [15:0] s, e);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] a, d);
    @(negedge clk_in);
    {wr, rd, addr, wdata} = {w, !w, a, d};
    @(negedge clk_in);
    {wr, rd} = 2'b00;
    chk("ack", {15'h0000, ack}, 16'h0001);
    v = rdata;
  endtask
  // Sensor path lags a few cycles through the synchroniser
  task automatic st(input logic [7:0] t, input logic [15:0] e);
    temp = t;
    repeat (6) @(negedge clk_in);
    acc(1'b0, S, 16'h0000);
    chk("status", v, e);
  endtask
  task automatic report_and_stop;
    $display("Checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ==========================================
  // Sequence
  initial begin
    {sys_rst_in, wr, rd, lock, done, rng, addr, wdata, temp} = {6'b100011, 32'h00000000, 8'h50};
    num_errors = 0;
    tests_run = 0;
    repeat (2) @(negedge clk_in);
    sys_rst_in = 1'b0;
    chk("reset", {en, hyst, 3'b000, rdg}, 16'h00FF);
    chk("status reset", sts, 16'h0000);
    acc(1'b0, C, 16'h0000); chk("sem first", v, 16'h0000);
    acc(1'b0, C, 16'h0000); chk("sem later", v, 16'h0100);
    acc(1'b1, C, 16'h0000); acc(1'b0, C, 16'h0000); chk("sem w0", v, 16'h0100);
    acc(1'b1, C, 16'h0100); acc(1'b0, C, 16'h0000); chk("sem w1", v, 16'h0000);
    acc(1'b1, C, 16'hFFFF); chk("en hyst", {11'h000, en, hyst}, 16'h001F);
    acc(1'b0, C, 16'h0000); chk("control", v, 16'hBC00);
    lock = 1'b1;
    acc(1'b1, C, 16'h0000); acc(1'b0, C, 16'h0000); chk("locked", v, 16'h8100);
    lock = 1'b0;
    acc(1'b1, S, 16'hFFFF);
    st(8'h50, 16'h040F);
    st(8'h80, 16'h041F);
    st(8'h81, 16'h043F);
    acc(1'b0, `TSC_OFF_READING, 16'h0000); chk("reading", v, 16'h0081);
    acc(1'b1, C, 16'h9000);
    st(8'h50, 16'h040F);
    st(8'h85, 16'h043F);
    // Stay clear of thresh..thresh+N, where a tripped comparator toggles
    st(8'h7F, 16'h041F);
    rng = 1'b0;
    st(8'h7F, 16'h001F);
    rng = 1'b1;
    done = 1'b0;
    st(8'h7F, 16'h001F);
    done = 1'b1;
    acc(1'b1, C, 16'h0000);
    st(8'h84, 16'h0000);
    acc(1'b0, 16'h1050, 16'h0000); chk("unmapped", v, 16'h0000);
    acc(1'b1, C, 16'h8000);
    sys_rst_in = 1'b1;
    @(negedge clk_in);
    sys_rst_in = 1'b0;
    chk("reset again", {en, hyst, 3'b000, rdg}, 16'h00FF);
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
